// ==== inc/modem_timing_pkg.sv ====
// Offsets, reset values and timing constants of the call timing bank
`default_nettype none
package modem_timing_pkg;
  localparam int REG_SLOTS = 41;
  localparam logic [5:0] IDX_RINGS_TO_ANSWER        = 6'h00;
  localparam logic [5:0] IDX_DIAL_WAIT_SECONDS      = 6'h01;
  localparam logic [5:0] IDX_DIALTONE_WAIT_SECONDS  = 6'h02;
  localparam logic [5:0] IDX_CARRIER_LOSS_WAIT      = 6'h03;
  localparam logic [5:0] IDX_DTMF_TONE_TIMING       = 6'h04;
  localparam logic [5:0] IDX_PULSE_BREAK_TIME       = 6'h05;
  localparam logic [5:0] IDX_PULSE_MAKE_TIME        = 6'h06;
  localparam logic [5:0] IDX_MISC_FUNCTION_ONE      = 6'h07;
  localparam logic [5:0] IDX_INTERRUPT_MASK         = 6'h08;
  localparam logic [5:0] IDX_INTERRUPT_STATUS       = 6'h09;
  localparam logic [5:0] IDX_MISC_FUNCTION_TWO      = 6'h0c;
  localparam logic [5:0] IDX_MISC_FUNCTION_THREE    = 6'h0d;
  localparam logic [5:0] IDX_PULSE_INTERDIGIT_TIME  = 6'h0e;
  localparam logic [5:0] IDX_ESCAPE_CHARACTER       = 6'h0f;
  localparam logic [5:0] IDX_ESCAPE_GUARD_DELAY     = 6'h10;
  localparam logic [5:0] IDX_OFFHOOK_INTRUSION_CFG  = 6'h11;
  localparam logic [5:0] IDX_ABSOLUTE_CURRENT_LEVEL = 6'h12;
  localparam logic [5:0] IDX_MISC_FUNCTION_FOUR     = 6'h13;
  localparam logic [5:0] IDX_LOOP_CURRENT_CONFIG    = 6'h15;
  localparam logic [5:0] IDX_BUSY_ON_TIME           = 6'h16;
  localparam logic [5:0] IDX_BUSY_OFF_TIME          = 6'h17;
  localparam logic [5:0] IDX_BUSY_TOLERANCE         = 6'h18;
  localparam logic [5:0] IDX_RINGBACK_ON_TIME       = 6'h19;
  localparam logic [5:0] IDX_RINGBACK_OFF_TIME      = 6'h1a;
  localparam logic [5:0] IDX_RINGBACK_TOLERANCE     = 6'h1b;
  localparam logic [5:0] IDX_DIALTONE_VALID_TIME    = 6'h1c;
  localparam logic [5:0] IDX_ANSWER_TONE_SECONDS    = 6'h1e;
  localparam logic [5:0] IDX_ANSWER_TO_DATA_DELAY   = 6'h1f;
  localparam logic [5:0] IDX_PLAIN_ONES_DETECT_LEN  = 6'h20;
  localparam logic [5:0] IDX_SCRAMBLED_ONES_DELAY   = 6'h21;
  localparam logic [5:0] IDX_SCRAMBLED_ONES_LENGTH  = 6'h22;
  localparam logic [5:0] IDX_DATA_DELAY_LOW         = 6'h23;
  localparam logic [5:0] IDX_DATA_DELAY_HIGH        = 6'h24;
  localparam logic [5:0] IDX_S1_PATTERN_LENGTH      = 6'h25;
  localparam logic [5:0] IDX_ONES_1200_AFTER_S1     = 6'h26;
  localparam logic [5:0] IDX_ONES_2400_LENGTH_LOW   = 6'h27;
  localparam logic [5:0] IDX_ONES_2400_LENGTH_HIGH  = 6'h28;
  // Slots 0x0a, 0x0b, 0x14 and 0x1d are reserved
  localparam logic [REG_SLOTS-1:0] SLOT_DEFINED = 41'h1ffdfeff3ff;
  localparam logic [7:0] RESET_VALUE [REG_SLOTS] = '{
    8'h00, 8'h02, 8'h03, 8'h0e, 8'h30, 8'h18, 8'h24, 8'h06,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h46, 8'h2b,
    8'h13, 8'h04, 8'h00, 8'h10, 8'h00, 8'h04, 8'h32, 8'h32,
    8'h0f, 8'h26, 8'h4b, 8'h07, 8'h0a, 8'h00, 8'h03, 8'h2d,
    8'h5d, 8'h09, 8'ha2, 8'hcb, 8'h08, 8'h3c, 8'h0c, 8'h78,
    8'h08};
  localparam logic [7:0]  SECONDS_CAP         = 8'h6d;
  localparam logic [11:0] INTERDIGIT_BASE_MS  = 12'h040;
  localparam logic [11:0] INTERDIGIT_STEP_MS  = 12'h00a;
  localparam int          INTRUSION_MODE_BIT  = 4;
  localparam int          CLK_PERIOD_NS       = 10;
  localparam int          DETECT_TICK_MS      = 10;
  localparam int          DETECT_TICK_CYCLES  = DETECT_TICK_MS * 1000000 / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== core/modem_timing_bank.sv ====
// AHB-Lite register bank of modem call timing parameters with detector qualifiers
// Behaviour
// [R01] Nonzero ring count enables auto answer; zero disables it; resets to zero.
// [R02] Dial wait seconds, capped at 109, reset 0x02.
// [R03] Dial-tone give-up time is dial-tone wait plus dial wait, each capped.
// [R04] Carrier loss hang-up wait in 53.33 ms units, reset 0x0E.
// [R05] One value sets DTMF tone length and gap, 5/3 ms units, reset 0x30.
// [R06] Pulse break and make counts separately held, reset 0x18 and 0x24.
// [R07] Interdigit pause equals 64 ms plus value times 10 ms.
// [R08] Escape character resets to 0x2B, guard delay resets to 0x13.
// [R09] Current level is intrusion threshold when mode bit 4 is zero.
// [R10] Busy nominal on and off times in 10 ms units, both 0x32.
// [R11] Busy accepted only if on and off lie strictly inside nominal plus/minus delta.
// [R12] Ringback nominal on 0x26 and off 0x4B, 53.333 ms units.
// [R13] Ringback accepted only if both times lie strictly inside their window.
// [R14] Dial tone reported only after staying valid for the detect time.
// [R15] Answer tone length in whole seconds, reset 0x03.
// [R16] Delay from answer tone end to data, 5/3 ms units, reset 0x2D.
// [R17] Unscrambled ones minimum detect time, reset 0x5D.
// [R18] Scrambled ones delay reset 0x09 and length reset 0xA2.
// [R19] Data delay is low plus 256 times high register.
// [R20] S1 pattern send time, 5/3 ms units, reset 0x3C.
// [R21] 1200 bps scrambled ones after S1, 53.3 ms units, reset 0x0C.
// [R22] Host writes no undefined register address.
// [R23] 2400 bps ones time is low plus 256 times high register.
// [R24] Every register eight bits, resets to its value, reads back last write.
`timescale 1ns/1ps
`default_nettype none
module modem_timing_bank
  import modem_timing_pkg::*;
#(
  parameter int TICK_CYCLES = DETECT_TICK_CYCLES
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        dialtone_raw,
  input  wire logic        busy_meas_valid,
  input  wire logic [8:0]  busy_on_meas,
  input  wire logic [8:0]  busy_off_meas,
  input  wire logic        ring_meas_valid,
  input  wire logic [8:0]  ring_on_meas,
  input  wire logic [8:0]  ring_off_meas,
  output logic             auto_answer_en,
  output logic [7:0]       rings_to_answer,
  output logic [7:0]       dial_wait_secs,
  output logic [7:0]       dialtone_giveup_secs,
  output logic [7:0]       carrier_loss_wait,
  output logic [7:0]       dtmf_tone_timing,
  output logic [7:0]       pulse_break_time,
  output logic [7:0]       pulse_make_time,
  output logic [11:0]      interdigit_ms,
  output logic [7:0]       escape_character,
  output logic [7:0]       escape_guard_delay,
  output logic             intrusion_abs_mode,
  output logic [7:0]       intrusion_threshold_ma,
  output logic [7:0]       busy_on_time,
  output logic [7:0]       busy_off_time,
  output logic             busy_tone_ok,
  output logic [7:0]       ringback_on_time,
  output logic [7:0]       ringback_off_time,
  output logic             ringback_ok,
  output logic             dialtone_detected,
  output logic [7:0]       answer_tone_seconds,
  output logic [7:0]       answer_to_data_delay,
  output logic [7:0]       plain_ones_detect_length,
  output logic [7:0]       scrambled_ones_delay,
  output logic [7:0]       scrambled_ones_length,
  output logic [15:0]      data_delay_units,
  output logic [7:0]       s1_pattern_length,
  output logic [7:0]       ones_1200_after_s1,
  output logic [15:0]      ones_2400_units
);

  logic [7:0]  regs_q [REG_SLOTS];
  logic [5:0]  addr_word;
  logic        addr_hit;
  logic        addr_phase;
  logic        wr_pend_q;
  logic [5:0]  wr_idx_q;
  logic [7:0]  rd_data_q;
  logic        dt_meta_q;
  logic        dt_sync_q;
  logic [19:0] tick_cnt_q;
  logic        tick;
  logic [7:0]  dt_cnt_q;
  logic [7:0]  dial_wait_capped;
  logic [7:0]  tone_wait_capped;

  // Strict window test, rearranged so nominal minus delta never wraps
  function automatic logic in_window(input logic [8:0] meas,
                                     input logic [7:0] nom,
                                     input logic [7:0] delta);
    logic [9:0] lo_side;
    logic [9:0] hi_side;
    lo_side = {1'b0, meas} + {2'b00, delta};
    hi_side = {2'b00, nom} + {2'b00, delta};
    return (lo_side > {2'b00, nom}) && ({1'b0, meas} < hi_side);
  endfunction

  // Zero wait state slave; every transfer answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h000000, rd_data_q};

  // Word address; anything past the bank or in a reserved slot is a miss
  assign addr_word  = haddr[7:2];
  assign addr_phase = hsel && hready && htrans[1];
  assign addr_hit   = (haddr[31:8] == 24'h000000) && (addr_word < 6'(REG_SLOTS))
                      && SLOT_DEFINED[addr_word];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 6'h00;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite && addr_hit; // R22
      wr_idx_q  <= addr_word;
    end
  end

  // Writes land in the data phase; misses are dropped silently
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < REG_SLOTS; i++)
        regs_q[i] <= RESET_VALUE[i]; // R24
    end
    else if (wr_pend_q)
    begin
      regs_q[wr_idx_q] <= hwdata[7:0]; // R24
    end
  end

  // Read data is sampled in the address phase, so a write still in its
  // data phase to the same slot is forwarded
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_data_q <= 8'h00;
    else if (addr_phase && !hwrite)
    begin
      if (!addr_hit)
        rd_data_q <= 8'h00;
      else if (wr_pend_q && (wr_idx_q == addr_word))
        rd_data_q <= hwdata[7:0]; // R24
      else
        rd_data_q <= regs_q[addr_word];
    end
  end

  assign rings_to_answer          = regs_q[IDX_RINGS_TO_ANSWER];
  assign carrier_loss_wait        = regs_q[IDX_CARRIER_LOSS_WAIT]; // R04
  assign dtmf_tone_timing         = regs_q[IDX_DTMF_TONE_TIMING]; // R05
  assign pulse_break_time         = regs_q[IDX_PULSE_BREAK_TIME]; // R06
  assign pulse_make_time          = regs_q[IDX_PULSE_MAKE_TIME]; // R06
  assign escape_character         = regs_q[IDX_ESCAPE_CHARACTER]; // R08
  assign escape_guard_delay       = regs_q[IDX_ESCAPE_GUARD_DELAY]; // R08
  assign busy_on_time             = regs_q[IDX_BUSY_ON_TIME]; // R10
  assign busy_off_time            = regs_q[IDX_BUSY_OFF_TIME]; // R10
  assign ringback_on_time         = regs_q[IDX_RINGBACK_ON_TIME]; // R12
  assign ringback_off_time        = regs_q[IDX_RINGBACK_OFF_TIME]; // R12
  assign answer_tone_seconds      = regs_q[IDX_ANSWER_TONE_SECONDS]; // R15
  assign answer_to_data_delay     = regs_q[IDX_ANSWER_TO_DATA_DELAY]; // R16
  assign plain_ones_detect_length = regs_q[IDX_PLAIN_ONES_DETECT_LEN]; // R17
  assign scrambled_ones_delay     = regs_q[IDX_SCRAMBLED_ONES_DELAY]; // R18
  assign scrambled_ones_length    = regs_q[IDX_SCRAMBLED_ONES_LENGTH]; // R18
  assign s1_pattern_length        = regs_q[IDX_S1_PATTERN_LENGTH]; // R20
  assign ones_1200_after_s1       = regs_q[IDX_ONES_1200_AFTER_S1]; // R21

  assign dial_wait_capped = (regs_q[IDX_DIAL_WAIT_SECONDS] > SECONDS_CAP) ? SECONDS_CAP
                            : regs_q[IDX_DIAL_WAIT_SECONDS]; // R02
  assign tone_wait_capped = (regs_q[IDX_DIALTONE_WAIT_SECONDS] > SECONDS_CAP) ? SECONDS_CAP
                            : regs_q[IDX_DIALTONE_WAIT_SECONDS]; // R03

  // Derived timing values; both capped terms sum to at most 218
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      auto_answer_en         <= 1'b0;
      dial_wait_secs         <= 8'h00;
      dialtone_giveup_secs   <= 8'h00;
      interdigit_ms          <= 12'h000;
      intrusion_abs_mode     <= 1'b0;
      intrusion_threshold_ma <= 8'h00;
      data_delay_units       <= 16'h0000;
      ones_2400_units        <= 16'h0000;
    end
    else
    begin
      auto_answer_en         <= (regs_q[IDX_RINGS_TO_ANSWER] != 8'h00); // R01
      dial_wait_secs         <= dial_wait_capped; // R02
      dialtone_giveup_secs   <= dial_wait_capped + tone_wait_capped; // R03
      interdigit_ms          <= INTERDIGIT_BASE_MS + 12'(regs_q[IDX_PULSE_INTERDIGIT_TIME]
                                * INTERDIGIT_STEP_MS); // R07
      intrusion_abs_mode     <= !regs_q[IDX_MISC_FUNCTION_FOUR][INTRUSION_MODE_BIT]; // R09
      intrusion_threshold_ma <= regs_q[IDX_MISC_FUNCTION_FOUR][INTRUSION_MODE_BIT]
                                ? 8'h00 : regs_q[IDX_ABSOLUTE_CURRENT_LEVEL]; // R09
      data_delay_units       <= {regs_q[IDX_DATA_DELAY_HIGH],
                                 regs_q[IDX_DATA_DELAY_LOW]}; // R19
      ones_2400_units        <= {regs_q[IDX_ONES_2400_LENGTH_HIGH],
                                 regs_q[IDX_ONES_2400_LENGTH_LOW]}; // R23
    end
  end

  // Verdicts hold until the next measurement arrives
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_tone_ok <= 1'b0;
      ringback_ok  <= 1'b0;
    end
    else
    begin
      if (busy_meas_valid)
        busy_tone_ok <= in_window(busy_on_meas, busy_on_time, regs_q[IDX_BUSY_TOLERANCE])
                        && in_window(busy_off_meas, busy_off_time,
                                     regs_q[IDX_BUSY_TOLERANCE]); // R11
      if (ring_meas_valid)
        ringback_ok <= in_window(ring_on_meas, ringback_on_time,
                                 regs_q[IDX_RINGBACK_TOLERANCE])
                       && in_window(ring_off_meas, ringback_off_time,
                                    regs_q[IDX_RINGBACK_TOLERANCE]); // R13
    end
  end

  // Tone flag comes from the analog side, so it is synchronised first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dt_meta_q <= 1'b0;
      dt_sync_q <= 1'b0;
    end
    else
    begin
      dt_meta_q <= dialtone_raw;
      dt_sync_q <= dt_meta_q;
    end
  end

  assign tick = (tick_cnt_q == 20'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick_cnt_q <= 20'h00000;
    else if (tick)
      tick_cnt_q <= 20'h00000;
    else
      tick_cnt_q <= tick_cnt_q + 20'h00001;
  end

  // Free-running tick: the first interval may be short by up to one tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dt_cnt_q          <= 8'h00;
      dialtone_detected <= 1'b0;
    end
    else if (!dt_sync_q)
    begin
      dt_cnt_q          <= 8'h00; // R14
      dialtone_detected <= 1'b0; // R14
    end
    else
    begin
      if (tick && (dt_cnt_q != 8'hff))
        dt_cnt_q <= dt_cnt_q + 8'h01;
      dialtone_detected <= (dt_cnt_q >= regs_q[IDX_DIALTONE_VALID_TIME]); // R14
    end
  end

  property p_write_readback;
    @(posedge hclk) disable iff (!hresetn)
    (addr_phase && hwrite && addr_hit) ##1 1'b1 |=>
      regs_q[$past(wr_idx_q)] == $past(hwdata[7:0]);
  endproperty
  a_write_readback: assert property (p_write_readback) // R24
    else $error("written value not held in register");

  property p_reserved_read;
    @(posedge hclk) disable iff (!hresetn)
    (addr_phase && !hwrite && !addr_hit) |=> (hrdata == 32'h00000000);
  endproperty
  a_reserved_read: assert property (p_reserved_read) // R22
    else $error("unmapped read not zero");

  property p_dial_cap;
    @(posedge hclk) disable iff (!hresetn)
    (dial_wait_secs <= SECONDS_CAP) && (dialtone_giveup_secs >= dial_wait_secs);
  endproperty
  a_dial_cap: assert property (p_dial_cap) // R02
    else $error("dial wait cap or give-up sum broken");

  property p_giveup_sum;
    @(posedge hclk) disable iff (!hresetn)
    hresetn && $stable(tone_wait_capped) && $stable(dial_wait_capped) |=>
      dialtone_giveup_secs == $past(dial_wait_capped) + $past(tone_wait_capped);
  endproperty
  a_giveup_sum: assert property (p_giveup_sum) // R03
    else $error("give-up time is not the sum of both waits");

  property p_auto_answer;
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_q && wr_idx_q == IDX_RINGS_TO_ANSWER && hwdata[7:0] == 8'h00)
      |=> ##1 !auto_answer_en;
  endproperty
  a_auto_answer: assert property (p_auto_answer) // R01
    else $error("zero ring count left auto answer on");

  property p_interdigit;
    @(posedge hclk) disable iff (!hresetn)
    hresetn |=> interdigit_ms == INTERDIGIT_BASE_MS
      + 12'($past(regs_q[IDX_PULSE_INTERDIGIT_TIME]) * INTERDIGIT_STEP_MS);
  endproperty
  a_interdigit: assert property (p_interdigit) // R07
    else $error("interdigit pause wrong");

  property p_busy_window;
    @(posedge hclk) disable iff (!hresetn)
    (busy_meas_valid && (busy_on_meas >= {1'b0, busy_on_time}
                                         + {1'b0, regs_q[IDX_BUSY_TOLERANCE]}))
      |=> !busy_tone_ok;
  endproperty
  a_busy_window: assert property (p_busy_window) // R11
    else $error("busy accepted outside window");

  property p_busy_accept;
    @(posedge hclk) disable iff (!hresetn)
    (busy_meas_valid
     && ({1'b0, busy_on_meas} + {2'b00, regs_q[IDX_BUSY_TOLERANCE]} > {2'b00, busy_on_time})
     && ({1'b0, busy_on_meas} < {2'b00, busy_on_time} + {2'b00, regs_q[IDX_BUSY_TOLERANCE]})
     && ({1'b0, busy_off_meas} + {2'b00, regs_q[IDX_BUSY_TOLERANCE]} > {2'b00, busy_off_time})
     && ({1'b0, busy_off_meas} < {2'b00, busy_off_time} + {2'b00, regs_q[IDX_BUSY_TOLERANCE]}))
      |=> busy_tone_ok;
  endproperty
  a_busy_accept: assert property (p_busy_accept) // R11
    else $error("busy rejected inside window");

  property p_ring_window;
    @(posedge hclk) disable iff (!hresetn)
    (ring_meas_valid && ({1'b0, ring_off_meas} + {2'b00, regs_q[IDX_RINGBACK_TOLERANCE]}
                         <= {2'b00, ringback_off_time}))
      |=> !ringback_ok;
  endproperty
  a_ring_window: assert property (p_ring_window) // R13
    else $error("ringback accepted outside window");

  property p_dialtone_drop;
    @(posedge hclk) disable iff (!hresetn)
    !dt_sync_q |=> !dialtone_detected [*1] ##1 (!dialtone_detected || dt_sync_q
      || (regs_q[IDX_DIALTONE_VALID_TIME] == 8'h00));
  endproperty
  a_dialtone_drop: assert property (p_dialtone_drop) // R14
    else $error("dial tone reported without a steady tone");

endmodule
`default_nettype wire

// ==== testbench/line_side_model.sv ====
// Line-side detector model: dial tone level and measured tone cadences
`timescale 1ns/1ps
`default_nettype none
module line_side_model (
  input  wire logic       hclk,
  output logic            dialtone_raw,
  output logic            busy_meas_valid,
  output logic [8:0]      busy_on_meas,
  output logic [8:0]      busy_off_meas,
  output logic            ring_meas_valid,
  output logic [8:0]      ring_on_meas,
  output logic [8:0]      ring_off_meas
);
  initial
  begin
    dialtone_raw = 1'b0;
    busy_meas_valid = 1'b0;
    ring_meas_valid = 1'b0;
    {busy_on_meas, busy_off_meas, ring_on_meas, ring_off_meas} = '0;
  end

  task automatic set_tone(input logic lvl);
    dialtone_raw <= lvl;
  endtask

  // Buses are not held past the pulse: inverted so a late sample is caught
  task automatic send(input logic ring, input logic [8:0] on, input logic [8:0] off);
    if (ring)
    begin
      ring_meas_valid <= 1'b1;
      ring_on_meas <= on;
      ring_off_meas <= off;
    end
    else
    begin
      busy_meas_valid <= 1'b1;
      busy_on_meas <= on;
      busy_off_meas <= off;
    end
    @(posedge hclk);
    ring_meas_valid <= 1'b0;
    busy_meas_valid <= 1'b0;
    ring_on_meas <= ~ring_on_meas;
    ring_off_meas <= ~ring_off_meas;
    busy_on_meas <= ~busy_on_meas;
    busy_off_meas <= ~busy_off_meas;
  endtask
endmodule
`default_nettype wire

// ==== testbench/modem_call_timing_params_bench.sv ====
// Self-checking bench for the modem call timing bank over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module modem_call_timing_params_bench;
  import modem_timing_pkg::*;
  localparam int TICK = 4;
  localparam logic [7:0] RST_TAB [41] = '{
    8'h00, 8'h02, 8'h03, 8'h0e, 8'h30, 8'h18, 8'h24, 8'h06, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h46, 8'h2b, 8'h13, 8'h04, 8'h00, 8'h10, 8'h00, 8'h04,
    8'h32, 8'h32, 8'h0f, 8'h26, 8'h4b, 8'h07, 8'h0a, 8'h00, 8'h03, 8'h2d, 8'h5d,
    8'h09, 8'ha2, 8'hcb, 8'h08, 8'h3c, 8'h0c, 8'h78, 8'h08};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = '0;
  wire         hready;
  logic        hreadyout, hresp, auto_answer_en, intrusion_abs_mode;
  logic        busy_tone_ok, ringback_ok, dialtone_detected;
  logic [31:0] hrdata;
  logic [11:0] interdigit_ms;
  logic [15:0] data_delay_units, ones_2400_units;
  logic [7:0]  rings_to_answer, dial_wait_secs, dialtone_giveup_secs, carrier_loss_wait;
  logic [7:0]  dtmf_tone_timing, pulse_break_time, pulse_make_time, escape_character;
  logic [7:0]  escape_guard_delay, intrusion_threshold_ma, busy_on_time, busy_off_time;
  logic [7:0]  ringback_on_time, ringback_off_time, answer_tone_seconds, answer_to_data_delay;
  logic [7:0]  plain_ones_detect_length, scrambled_ones_delay, scrambled_ones_length;
  logic [7:0]  s1_pattern_length, ones_1200_after_s1;
  logic        dialtone_raw, busy_meas_valid, ring_meas_valid;
  logic [8:0]  busy_on_meas, busy_off_meas, ring_on_meas, ring_off_meas;
  int          err_total = 0;
  int          n_checks = 0;
  int          seed = 32'h441c;
  int          cyc = 0;
  int          mdl [41];

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  modem_timing_bank #(.TICK_CYCLES(TICK)) modem_timing_bank_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .dialtone_raw, .busy_meas_valid, .busy_on_meas,
    .busy_off_meas, .ring_meas_valid, .ring_on_meas, .ring_off_meas, .auto_answer_en,
    .rings_to_answer, .dial_wait_secs, .dialtone_giveup_secs, .carrier_loss_wait,
    .dtmf_tone_timing, .pulse_break_time, .pulse_make_time, .interdigit_ms,
    .escape_character, .escape_guard_delay, .intrusion_abs_mode, .intrusion_threshold_ma,
    .busy_on_time, .busy_off_time, .busy_tone_ok, .ringback_on_time, .ringback_off_time,
    .ringback_ok, .dialtone_detected, .answer_tone_seconds, .answer_to_data_delay,
    .plain_ones_detect_length, .scrambled_ones_delay, .scrambled_ones_length,
    .data_delay_units, .s1_pattern_length, .ones_1200_after_s1, .ones_2400_units);

  line_side_model lm (
    .hclk, .dialtone_raw, .busy_meas_valid, .busy_on_meas, .busy_off_meas,
    .ring_meas_valid, .ring_on_meas, .ring_off_meas);

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic bit defd(input int i);
    return i < 41 && !(i inside {10, 11, 20, 29});
  endfunction

  function automatic int cap(input int v);
    return v > 109 ? 109 : v;
  endfunction

  // Called at a rising edge; returns at the edge that ends the data phase
  task automatic bus(input logic wr, input int idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= 32'(idx * 4);
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    cmp_flag("hresp", 1'b0, hresp);
    cmp_flag("hreadyout", 1'b1, hreadyout);
  endtask

  task automatic wr(input int idx, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, d, rd);
    if (defd(idx))
      mdl[idx] = d[7:0];
  endtask

  task automatic rdchk(input int idx);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    cmp_val($sformatf("reg_%0h", idx), defd(idx) ? 32'(mdl[idx]) : 32'h0, rd);
  endtask

  task automatic read_all();
    for (int i = 0; i < 43; i++)
      rdchk(i);
    rdchk(64);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 41; i++)
      mdl[i] = RST_TAB[i];
    @(posedge hclk);
  endtask

  // Derived outputs lag the register by one edge, so let two pass
  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
    cmp_flag("auto_answer_en", mdl[0] != 0, auto_answer_en);
    cmp_val("rings", mdl[0], rings_to_answer);
    cmp_val("dial_wait", cap(mdl[1]), dial_wait_secs);
    cmp_val("giveup", cap(mdl[1]) + cap(mdl[2]), dialtone_giveup_secs);
    cmp_val("carrier_loss", mdl[3], carrier_loss_wait);
    cmp_val("dtmf", mdl[4], dtmf_tone_timing);
    cmp_val("break", mdl[5], pulse_break_time);
    cmp_val("make", mdl[6], pulse_make_time);
    cmp_val("interdigit", 64 + 10 * mdl[14], interdigit_ms);
    cmp_val("esc_char", mdl[15], escape_character);
    cmp_val("esc_guard", mdl[16], escape_guard_delay);
    cmp_flag("abs_mode", !mdl[19][4], intrusion_abs_mode);
    cmp_val("threshold", mdl[19][4] ? 0 : mdl[18], intrusion_threshold_ma);
    cmp_val("busy_on", mdl[22], busy_on_time);
    cmp_val("busy_off", mdl[23], busy_off_time);
    cmp_val("ring_on", mdl[25], ringback_on_time);
    cmp_val("ring_off", mdl[26], ringback_off_time);
    cmp_val("ans_tone", mdl[30], answer_tone_seconds);
    cmp_val("ans_data", mdl[31], answer_to_data_delay);
    cmp_val("plain_ones", mdl[32], plain_ones_detect_length);
    cmp_val("scr_delay", mdl[33], scrambled_ones_delay);
    cmp_val("scr_len", mdl[34], scrambled_ones_length);
    cmp_val("data_delay", mdl[35] + 256 * mdl[36], data_delay_units);
    cmp_val("s1_len", mdl[37], s1_pattern_length);
    cmp_val("ones_1200", mdl[38], ones_1200_after_s1);
    cmp_val("ones_2400", mdl[39] + 256 * mdl[40], ones_2400_units);
    @(posedge hclk);
  endtask

  // Measured times just inside and just on each edge of the window
  task automatic cadence(input logic ring);
    int nom, noff, d, dv, on, off;
    logic exp;
    nom = 20 + ($random(seed) & 32'h7f);
    noff = 20 + ($random(seed) & 32'h7f);
    d = 1 + ($random(seed) & 32'h0f);
    wr(ring ? 25 : 22, nom);
    wr(ring ? 26 : 23, noff);
    wr(ring ? 27 : 24, d);
    for (int k = 0; k < 8; k++)
    begin
      dv = (k % 4 < 2) ? k % 2 - d : d - 1 + k % 2;
      on = nom + (k < 4 ? dv : 0);
      off = noff + (k < 4 ? 0 : dv);
      exp = nom - d < on && on < nom + d && noff - d < off && off < noff + d;
      lm.send(ring, 9'(on), 9'(off));
      @(posedge hclk);
      #1;
      cmp_flag("cadence_ok", exp, ring ? ringback_ok : busy_tone_ok);
      @(posedge hclk);
    end
  endtask

  task automatic tone(input int n);
    int c;
    wr(28, n);
    lm.set_tone(1'b1);
    c = 0;
    while (dialtone_detected !== 1'b1 && c < 100)
    begin
      @(posedge hclk);
      c++;
    end
    cmp_flag("dialtone_window", 1'b1, c <= n * TICK + 5 && (n == 0 || c > (n - 1) * TICK));
    lm.set_tone(1'b0);
    repeat (4) @(posedge hclk);
    #1;
    cmp_flag("dialtone_clear", 1'b0, dialtone_detected);
    @(posedge hclk);
    lm.set_tone(1'b1);
    @(posedge hclk);
    lm.set_tone(1'b0);
    repeat (12) @(posedge hclk);
    #1;
    cmp_flag("dialtone_glitch", 1'b0, dialtone_detected);
    @(posedge hclk);
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    do_reset();
    settle();
    read_all();
    wr(1, 109);
    wr(2, 110);
    wr(0, 1);
    wr(19, 0);
    wr(18, 32'hffff_ff5a);
    settle();
    wr(1, 255);
    wr(2, 108);
    wr(0, 0);
    wr(14, 255);
    settle();
    repeat (3)
    begin
      for (int i = 0; i < 43; i++)
        if (defd(i))
          wr(i, $random(seed));
      settle();
      read_all();
    end
    repeat (2)
    begin
      cadence(1'b0);
      cadence(1'b1);
    end
    tone(3);
    tone(0);
    do_reset();
    settle();
    read_all();
    wrap_up();
  end
endmodule
`default_nettype wire
